// ### design/irq_regs_pkg.sv
package irq_regs_pkg;

    // Register indexes; byte address is index times four
    localparam int NUM_REGS = 13;
    localparam logic [3:0] IDX_HALL_EDGE = 4'h0;
    localparam logic [3:0] IDX_EXT_EDGE = 4'h1;
    localparam logic [3:0] IDX_CTRL0 = 4'h2;
    localparam logic [3:0] IDX_CTRL1 = 4'h3;
    localparam logic [3:0] IDX_CTRL2 = 4'h4;
    localparam logic [3:0] IDX_CTRL3 = 4'h5;
    localparam logic [3:0] IDX_SUB0 = 4'h6;
    localparam logic [3:0] IDX_SUB1 = 4'h7;
    localparam logic [3:0] IDX_SUB2 = 4'h8;
    localparam logic [3:0] IDX_SUB3 = 4'h9;
    localparam logic [3:0] IDX_SUB4 = 4'ha;
    localparam logic [3:0] IDX_SUB5 = 4'hb;
    localparam logic [3:0] IDX_SUB6 = 4'hc;
    localparam logic [3:0] ADDR_IDX_LSB = 4'h2;

    // Value after reset and implemented bits per register
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] WMASK [0:12] = '{8'h7f, 8'h03, 8'h7f, 8'hff, 8'hff, 8'hff,
        8'h77, 8'hff, 8'hff, 8'h33, 8'h33, 8'h33, 8'h33};

    // Edge select encoding
    typedef enum logic [1:0] {
        EDGE_OFF = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_BOTH = 2'h3
    } edge_sel_e;

    // Field positions
    localparam int HSEL_BIT = 6;
    localparam int EXT_EDGE_LSB = 0;
    localparam int GLOBAL_EN_BIT = 0;
    localparam int FLAG_LSB = 4;
    localparam int COMP0_BIT = 6;
    localparam int EXTPIN_BIT = 5;
    localparam int EEPROM_BIT = 7;
    localparam int LOWVOLT_BIT = 6;
    localparam int FILT_BIT = 4;
    localparam int TIMEBASE_BIT = 7;
    localparam int SERIAL_BIT = 5;
    localparam int TWOWIRE_BIT = 4;
    localparam int HALL_A_BIT = 4;
    localparam int CAP_CMP_BIT = 7;
    localparam int CAP_OVF_BIT = 6;
    localparam int ADC_LIM_BIT = 5;
    localparam int ADC_DONE_BIT = 4;
    localparam int PWM_PER_BIT = 7;
    localparam int PWM_DUTY_LSB = 4;
    localparam int TMR_A_BIT = 5;
    localparam int TMR_P_BIT = 4;

    // Group flag target per sub-group 0..6, sub-group per timer 0..3
    localparam logic [3:0] GRP_REG [0:6] = '{IDX_CTRL0, IDX_CTRL1, IDX_CTRL2, IDX_CTRL2,
        IDX_CTRL2, IDX_CTRL2, IDX_CTRL3};
    localparam int GRP_BIT [0:6] = '{4, 5, 4, 5, 6, 7, 6};
    localparam logic [3:0] TMR_REG [0:3] = '{IDX_SUB4, IDX_SUB5, IDX_SUB3, IDX_SUB6};

    // AHB-Lite codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

endpackage : irq_regs_pkg

// ### design/motor_mcu_interrupt_regs.sv
`timescale 1ns/1ps
// Contract
// - hall source select: pins or comparators
// - hall C edge field off/rise/fall/both
// - hall B edge field same encoding
// - hall A edge field same encoding
// - external pin edge field, upper bits zero
// - unimplemented bits read zero, ignore writes
// - global enable gates every interrupt
// - control 0 flags and enables layout
// - control 1 flags and enables layout
// - control 2 group flags and enables
// - control 3 flags and enables layout
// - hall sub-group per-channel flags and enables
// - capture and converter sub-group layout
// - pwm period and duty sub-group
// - timers 2 and 0 sub-group layout
// - timers 1 and 3 same layout
// - hall flag set on selected edge
// - flags set regardless of enable
// - acceptance clears global enable
// - service clears group flag, channels stay; set wins, so it stays set while an enabled channel flag is set
module motor_mcu_interrupt_regs
    import irq_regs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [2:0] hall_pins,
    input wire logic [2:0] comparator_outputs,
    input wire logic ext_pin,
    input wire logic comp0_evt,
    input wire logic filtered_input_evt,
    input wire logic eeprom_write_evt,
    input wire logic low_volt_evt,
    input wire logic timebase_evt,
    input wire logic serial_port_evt,
    input wire logic two_wire_evt,
    input wire logic capture_compare_evt,
    input wire logic capture_overflow_evt,
    input wire logic adc_limit_evt,
    input wire logic adc_done_evt,
    input wire logic pwm_period_evt,
    input wire logic [2:0] pwm_duty_evt,
    input wire logic [3:0] timer_cmp_a_evt,
    input wire logic [3:0] timer_cmp_p_evt,
    output logic irq_req,
    input wire logic irq_ack,
    input wire logic [1:0] irq_ack_reg,
    input wire logic [2:0] irq_ack_bit
);

    logic [7:0] regs_r [0:12];
    logic [7:0] reg_nxt [0:12];
    logic [7:0] set_m [0:12];
    logic [7:0] clr_m [0:12];
    logic [6:0] pin_raw;
    logic [6:0] sync1_r;
    logic [6:0] sync2_r;
    logic [6:0] sync3_r;
    logic [6:0] stable_r;
    logic [3:0] chan_lvl;
    logic [3:0] chan_prev_r;
    logic [3:0] chan_hit;
    logic addr_ok;
    logic in_map;
    logic wr_pend_r;
    logic [3:0] wr_idx_r;
    logic [31:0] hrdata_r;
    logic pend;

    // Edge match for one channel
    function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
                                      input logic cur);
        logic hit;
        hit = 1'b0;
        case (sel)
            EDGE_RISE: hit = !prev && cur;
            EDGE_FALL: hit = prev && !cur;
            EDGE_BOTH: hit = prev != cur;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : edge_hit

    // Three-stage synchroniser with agreement filter on every pin
    assign pin_raw = {ext_pin, comparator_outputs, hall_pins};
    for (genvar gi = 0; gi < 7; gi++) begin : g_sync
        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                sync1_r[gi] <= 1'b0;
                sync2_r[gi] <= 1'b0;
                sync3_r[gi] <= 1'b0;
                stable_r[gi] <= 1'b0;
            end else begin
                sync1_r[gi] <= pin_raw[gi];
                sync2_r[gi] <= sync1_r[gi];
                sync3_r[gi] <= sync2_r[gi];
                // Level moves only once two stages agree
                if (sync2_r[gi] == sync3_r[gi]) begin
                    stable_r[gi] <= sync2_r[gi];
                end
            end
        end
    end

    // source mux for hall channels
    // Switching the source may itself look like an edge
    assign chan_lvl = {stable_r[6],
                       regs_r[IDX_HALL_EDGE][HSEL_BIT] ? stable_r[5:3] : stable_r[2:0]};

    // Previous level per channel for edge detection
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            chan_prev_r <= 4'h0;
        end else begin
            chan_prev_r <= chan_lvl;
        end
    end

    // hall edge fields, external pin field
    for (genvar ch = 0; ch < 4; ch++) begin : g_edge
        if (ch < 3) begin : g_hall
            assign chan_hit[ch] = edge_hit(regs_r[IDX_HALL_EDGE][2*ch +: 2],
                                           chan_prev_r[ch], chan_lvl[ch]);
        end else begin : g_ext
            assign chan_hit[ch] = edge_hit(regs_r[IDX_EXT_EDGE][EXT_EDGE_LSB +: 2],
                                           chan_prev_r[ch], chan_lvl[ch]);
        end
    end

    // Hardware set and clear masks
    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            set_m[i] = 8'h00;
            clr_m[i] = 8'h00;
        end
        // primary sources, set whatever the enable
        set_m[IDX_CTRL0][COMP0_BIT] = comp0_evt;
        set_m[IDX_CTRL0][EXTPIN_BIT] = chan_hit[3];
        set_m[IDX_CTRL1][EEPROM_BIT] = eeprom_write_evt;
        set_m[IDX_CTRL1][LOWVOLT_BIT] = low_volt_evt;
        set_m[IDX_CTRL1][FILT_BIT] = filtered_input_evt;
        set_m[IDX_CTRL3][TIMEBASE_BIT] = timebase_evt;
        set_m[IDX_CTRL3][SERIAL_BIT] = serial_port_evt;
        set_m[IDX_CTRL3][TWOWIRE_BIT] = two_wire_evt;
        for (int c = 0; c < 3; c++) begin
            set_m[IDX_SUB0][HALL_A_BIT + c] = chan_hit[c];
        end
        set_m[IDX_SUB1][CAP_CMP_BIT] = capture_compare_evt;
        set_m[IDX_SUB1][CAP_OVF_BIT] = capture_overflow_evt;
        set_m[IDX_SUB1][ADC_LIM_BIT] = adc_limit_evt;
        set_m[IDX_SUB1][ADC_DONE_BIT] = adc_done_evt;
        set_m[IDX_SUB2][PWM_PER_BIT] = pwm_period_evt;
        for (int d = 0; d < 3; d++) begin
            set_m[IDX_SUB2][PWM_DUTY_LSB + d] = pwm_duty_evt[d];
        end
        for (int t = 0; t < 4; t++) begin
            set_m[TMR_REG[t]][TMR_A_BIT] = timer_cmp_a_evt[t];
            set_m[TMR_REG[t]][TMR_P_BIT] = timer_cmp_p_evt[t];
        end
        // enabled sub flag raises its group flag
        for (int g = 0; g < 7; g++) begin
            if (|(regs_r[IDX_SUB0 + g][7:4] & regs_r[IDX_SUB0 + g][3:0])) begin
                set_m[GRP_REG[g]][GRP_BIT[g]] = 1'b1;
            end
        end
        // service clears enable and the primary flag only
        if (irq_ack) begin
            clr_m[IDX_CTRL0][GLOBAL_EN_BIT] = 1'b1;
            if (irq_ack_bit >= 3'(FLAG_LSB)) begin
                clr_m[IDX_CTRL0 + irq_ack_reg][irq_ack_bit] = 1'b1;
            end
        end
    end

    // Next value: write, then clear, then set; set wins over any clear
    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            reg_nxt[i] = (((wr_pend_r && wr_idx_r == 4'(i)) ? hwdata[7:0] : regs_r[i])
                          & ~clr_m[i] | set_m[i]) & WMASK[i];
        end
    end

    // Register file
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_r[i] <= REG_RST;
            end
        end else begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_r[i] <= reg_nxt[i];
            end
        end
    end

    // global enable gates the enabled pending requests
    assign pend = |(regs_r[IDX_CTRL0][6:4] & regs_r[IDX_CTRL0][3:1])
                | |(regs_r[IDX_CTRL1][7:4] & regs_r[IDX_CTRL1][3:0])
                | |(regs_r[IDX_CTRL2][7:4] & regs_r[IDX_CTRL2][3:0])
                | |(regs_r[IDX_CTRL3][7:4] & regs_r[IDX_CTRL3][3:0]);
    assign irq_req = regs_r[IDX_CTRL0][GLOBAL_EN_BIT] && pend;

    // AHB-Lite address decode; zero wait states
    assign addr_ok = hsel && htrans == HTRANS_NONSEQ && hready;
    assign in_map = haddr[31:6] == 26'h0 && haddr[5:2] < 4'(NUM_REGS);

    // Address phase capture; read data taken from next state
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wr_pend_r <= 1'b0;
            wr_idx_r <= 4'h0;
            hrdata_r <= 32'h0;
        end else begin
            wr_pend_r <= addr_ok && hwrite && in_map;
            wr_idx_r <= haddr[5:2];
            // Unmapped reads return zero, upper bytes always zero
            if (addr_ok && !hwrite && in_map) begin
                hrdata_r <= {24'h0, reg_nxt[haddr[5:2]]};
            end else begin
                hrdata_r <= 32'h0;
            end
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_HSEL_MUX: assert property (
        regs_r[IDX_HALL_EDGE][HSEL_BIT] |-> chan_lvl[2:0] == stable_r[5:3])
        else $error("hall channels not fed from comparators");
    AST_HALL_A_RISE: assert property (
        (regs_r[IDX_HALL_EDGE][1:0] == EDGE_RISE && !chan_prev_r[0] && chan_lvl[0])
        |=> regs_r[IDX_SUB0][HALL_A_BIT])
        else $error("hall A rising edge not flagged");
    AST_HALL_C_OFF: assert property (
        (regs_r[IDX_HALL_EDGE][5:4] == EDGE_OFF && !regs_r[IDX_SUB0][6]
         && !(wr_pend_r && wr_idx_r == IDX_SUB0)) |=> !regs_r[IDX_SUB0][6])
        else $error("hall C flagged while disabled");
    AST_HALL_B_FALL: assert property (
        (regs_r[IDX_HALL_EDGE][3:2] == EDGE_FALL && chan_prev_r[1] && !chan_lvl[1])
        |=> regs_r[IDX_SUB0][HALL_A_BIT + 1])
        else $error("hall B falling edge not flagged");
    AST_EXT_BOTH: assert property (
        (regs_r[IDX_EXT_EDGE][1:0] == EDGE_BOTH && $changed(chan_lvl[3]))
        |=> regs_r[IDX_CTRL0][EXTPIN_BIT])
        else $error("external pin edge not flagged");
    AST_UNIMPL_ZERO: assert property (
        regs_r[IDX_CTRL0][7] == 1'b0 && regs_r[IDX_EXT_EDGE][7:2] == 6'h0
        && hrdata[31:8] == 24'h0 && (regs_r[IDX_SUB3] & 8'hcc) == 8'h00)
        else $error("unimplemented bit not zero");
    AST_GLOBAL_GATE: assert property (
        !regs_r[IDX_CTRL0][GLOBAL_EN_BIT] |-> !irq_req)
        else $error("interrupt raised with global enable off");
    AST_FLAG_NO_EN: assert property (
        (comp0_evt && !regs_r[IDX_CTRL0][3]) |=> regs_r[IDX_CTRL0][COMP0_BIT])
        else $error("flag lost while its enable is off");
    AST_ACK_EMI: assert property (
        irq_ack |=> !regs_r[IDX_CTRL0][GLOBAL_EN_BIT] ##1
        (!irq_req || regs_r[IDX_CTRL0][GLOBAL_EN_BIT]))
        else $error("global enable not cleared on acceptance");
    AST_HALL_SERVICE: assert property (
        (irq_ack && irq_ack_reg == 2'h0 && irq_ack_bit == 3'h4 && regs_r[IDX_SUB0][4]
         && !(wr_pend_r && wr_idx_r == IDX_SUB0)) |=> regs_r[IDX_SUB0][4])
        else $error("hall channel flag cleared by service");
    AST_GROUP_SET: assert property (
        |(regs_r[IDX_SUB1][7:4] & regs_r[IDX_SUB1][3:0]) |=> regs_r[IDX_CTRL1][5])
        else $error("group flag not raised by enabled sub flag");
    AST_WRITE_TAKES: assert property (
        (wr_pend_r && wr_idx_r == IDX_HALL_EDGE)
        |=> regs_r[IDX_HALL_EDGE] == ($past(hwdata[7:0]) & WMASK[0]))
        else $error("write to edge register not stored");

    // Further checks on bus, sources and grouping
    // read data zero outside data phase
    AST_RD_IDLE_ZERO: assert property (
        !$past(addr_ok && !hwrite) |-> hrdata == 32'h0)
        else $error("read data not zero outside its data phase");
    AST_HREADY_OKAY: assert property (
        hreadyout && hresp == HRESP_OKAY)
        else $error("bus not ready or response not okay");
    AST_ACK_FLAG_CLR: assert property (
        (irq_ack && irq_ack_reg == 2'h0 && irq_ack_bit == 3'(EXTPIN_BIT) && !chan_hit[3])
        |=> !regs_r[IDX_CTRL0][EXTPIN_BIT])
        else $error("serviced pin flag not cleared");
    AST_PWM_SET: assert property (
        pwm_period_evt |=> regs_r[IDX_SUB2][PWM_PER_BIT])
        else $error("pwm period flag not set");
    AST_TMR0_SET: assert property (
        timer_cmp_a_evt[0] |=> regs_r[IDX_SUB4][TMR_A_BIT])
        else $error("timer 0 compare A flag not set");
    AST_TMR1_SET: assert property (
        timer_cmp_p_evt[1] |=> regs_r[IDX_SUB5][TMR_P_BIT])
        else $error("timer 1 compare P flag not set");
    AST_CAP_SET: assert property (
        capture_overflow_evt |=> regs_r[IDX_SUB1][CAP_OVF_BIT])
        else $error("capture overflow flag not set");
    AST_CTRL1_SET: assert property (
        eeprom_write_evt |=> regs_r[IDX_CTRL1][EEPROM_BIT])
        else $error("eeprom write flag not set");
    AST_CTRL3_SET: assert property (
        timebase_evt |=> regs_r[IDX_CTRL3][TIMEBASE_BIT])
        else $error("time base flag not set");
    AST_CTRL2_GROUP: assert property (
        |(regs_r[IDX_SUB2][7:4] & regs_r[IDX_SUB2][3:0]) |=> regs_r[IDX_CTRL2][4])
        else $error("pwm group flag not raised");
    AST_HALL_GROUP: assert property (
        |(regs_r[IDX_SUB0][6:4] & regs_r[IDX_SUB0][2:0]) |=> regs_r[IDX_CTRL0][4])
        else $error("hall group flag not raised");
    AST_SYNC_FILTER: assert property (
        (sync2_r[0] != sync3_r[0]) |=> stable_r[0] == $past(stable_r[0]))
        else $error("pin level moved before stages agreed");

    COV_HALL_IRQ: cover property (regs_r[IDX_SUB0][4] ##[1:4] irq_req);
    COV_ACK: cover property (irq_req ##1 irq_ack);
    COV_SET_CLR_SAME: cover property (irq_ack && comp0_evt && irq_ack_bit == 3'h6);
    COV_COMP_SRC: cover property (regs_r[IDX_HALL_EDGE][HSEL_BIT] && chan_hit[0]);

endmodule : motor_mcu_interrupt_regs

// ### verif/cpu_partner.sv
`timescale 1ns/1ps
// CPU side: accepts a pending request after a chosen delay
module cpu_partner (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic irq_req,
    input wire logic ack_go,
    input wire logic [3:0] ack_dly,
    input wire logic [1:0] ack_reg_sel,
    input wire logic [2:0] ack_bit_sel,
    output logic irq_ack,
    output logic [1:0] irq_ack_reg,
    output logic [2:0] irq_ack_bit
);
    logic [3:0] wait_r;

    // one acceptance pulse per pending request
    always_ff @(posedge core_clk) begin
        if (!rst_n || !ack_go || !irq_req || irq_ack) begin
            wait_r <= 4'h0;
            irq_ack <= 1'b0;
        end else if (wait_r == ack_dly) begin
            irq_ack <= 1'b1;
        end else begin
            wait_r <= wait_r + 4'h1;
        end
    end

    // Selectors mean nothing without the pulse, so scramble them then
    assign irq_ack_reg = irq_ack ? ack_reg_sel : ~ack_reg_sel;
    assign irq_ack_bit = irq_ack ? ack_bit_sel : ~ack_bit_sel;
endmodule : cpu_partner

// ### verif/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) cmp(n, 8'(e), 8'(a))
module tb;
    import irq_regs_pkg::*;
    logic core_clk, rst_n, hsel, hwrite, hreadyout, hresp, irq_req, irq_ack, ext_pin, ack_go;
    logic [1:0] htrans, irq_ack_reg, ack_reg_sel;
    logic [2:0] hsize, irq_ack_bit, hall_pins, comp_out, ack_bit_sel;
    logic [3:0] ack_dly;
    logic [31:0] haddr, hwdata, hrdata;
    logic [22:0] evt;
    int mdl [0:13];
    int fail_count, check_count;
    // Flag home of the single-bit event sources
    localparam int EV_REG [0:14] = '{2, 3, 3, 3, 5, 5, 5, 7, 7, 7, 7, 8, 8, 8, 8};
    localparam int EV_BIT [0:14] = '{6, 4, 7, 6, 7, 5, 4, 7, 6, 5, 4, 7, 4, 5, 6};

    motor_mcu_interrupt_regs i_motor_mcu_interrupt_regs (.core_clk(core_clk), .rst_n(rst_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .hall_pins(hall_pins), .comparator_outputs(comp_out),
        .ext_pin(ext_pin), .comp0_evt(evt[0]), .filtered_input_evt(evt[1]),
        .eeprom_write_evt(evt[2]), .low_volt_evt(evt[3]), .timebase_evt(evt[4]),
        .serial_port_evt(evt[5]), .two_wire_evt(evt[6]), .capture_compare_evt(evt[7]),
        .capture_overflow_evt(evt[8]), .adc_limit_evt(evt[9]), .adc_done_evt(evt[10]),
        .pwm_period_evt(evt[11]), .pwm_duty_evt(evt[14:12]), .timer_cmp_a_evt(evt[18:15]),
        .timer_cmp_p_evt(evt[22:19]), .irq_req(irq_req), .irq_ack(irq_ack),
        .irq_ack_reg(irq_ack_reg), .irq_ack_bit(irq_ack_bit));

    cpu_partner i_cpu_partner (.core_clk(core_clk), .rst_n(rst_n), .irq_req(irq_req),
        .ack_go(ack_go), .ack_dly(ack_dly), .ack_reg_sel(ack_reg_sel),
        .ack_bit_sel(ack_bit_sel), .irq_ack(irq_ack), .irq_ack_reg(irq_ack_reg),
        .irq_ack_bit(irq_ack_bit));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] a);
        check_count++;
        if (a !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, a);
            fail_count++;
        end
    endtask : cmp

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick

    // Bounded wait; a stuck ready ends the run
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            results();
        end
    endtask : wait_rdy

    task automatic bus(input logic w, input int idx, input logic [7:0] d, output logic [7:0] q);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= 32'(idx) << 2;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_rdy();
        q = hrdata[7:0];
    endtask : bus

    task automatic wr(input int idx, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, idx, d, q);
        if (idx < NUM_REGS) mdl[idx] = d & WMASK[idx];
    endtask : wr

    task automatic rd(input int idx);
        logic [7:0] q;
        bus(1'b0, idx, 8'h00, q);
        `CHK("register", mdl[idx], q);
        `CHK("hresp", HRESP_OKAY, hresp);
    endtask : rd

    // Request goes out only with global enable and an enabled primary flag
    function automatic logic irq_exp();
        int a;
        a = (mdl[2] >> 3) & mdl[2] & 14;
        for (int i = 3; i < 6; i++) a = a | ((mdl[i] >> 4) & mdl[i] & 15);
        return (mdl[2] & 1) != 0 && a != 0;
    endfunction : irq_exp

    task automatic rd_all();
        for (int i = 0; i < 14; i++) rd(i);
        `CHK("irq_req", irq_exp(), irq_req);
    endtask : rd_all

    // One-cycle event pulse; the model sets flags, then enabled groups
    task automatic pulse(input logic [22:0] m);
        int r, b;
        evt <= m;
        tick(1);
        evt <= '0;
        for (int i = 0; i < 23; i++) begin
            r = i < 15 ? EV_REG[i] : int'(TMR_REG[(i - 15) % 4]);
            b = i < 15 ? EV_BIT[i] : (i < 19 ? 5 : 4);
            if (m[i]) mdl[r] = mdl[r] | (1 << b);
        end
        for (int s = 0; s < 7; s++) begin
            if (((mdl[6 + s] >> 4) & mdl[6 + s] & 15) != 0) begin
                mdl[int'(GRP_REG[s])] = mdl[int'(GRP_REG[s])] | (1 << GRP_BIT[s]);
            end
        end
        tick(3);
    endtask : pulse

    initial begin
        logic sel;
        logic ex;
        {rst_n, hsel, hwrite, ext_pin, ack_go, htrans, ack_reg_sel, ack_bit_sel} = '0;
        {haddr, hwdata, hall_pins, comp_out, evt, ack_dly} = '0;
        hsize = 3'h2;
        foreach (mdl[i]) mdl[i] = 0;
        fail_count = 0;
        check_count = 0;
        void'($urandom(23483));
        tick(10);
        rst_n <= 1'b1;
        tick(1);
        // Unmapped write must vanish, all reads zero
        wr(13, 8'hff);
        rd_all();
        $display("reset test done");
        // Subgroups first so no group flag lingers into primaries
        for (int i = 12; i >= 0; i--) begin
            wr(i, 8'($urandom));
            rd(i);
            wr(i, 8'h00);
        end
        $display("access test done");
        // flags set with any enables, groups follow enabled sub flags
        repeat (8) begin
            for (int i = 2; i < 13; i++) wr(i, 8'($urandom) & 8'h0f);
            pulse(23'($urandom));
            rd_all();
            for (int i = 12; i >= 2; i--) wr(i, 8'h00);
        end
        $display("event test done");
        // every edge code, both directions, source picked at random per pass
        for (int md = 0; md < 4; md++) begin
            for (int up = 0; up < 2; up++) begin
                sel = 1'($urandom);
                hall_pins <= {3{~up[0]}};
                comp_out <= {3{~up[0]}};
                ext_pin <= ~up[0];
                tick(8);
                wr(0, {1'b0, sel, 6'(md * 21)});
                wr(1, 8'(md));
                wr(6, 8'h00);
                wr(2, 8'h00);
                if (sel) comp_out <= {3{up[0]}};
                else hall_pins <= {3{up[0]}};
                ext_pin <= up[0];
                tick(8);
                ex = md == 3 || (md == 1 && up == 1) || (md == 2 && up == 0);
                mdl[6] = ex ? 8'h70 : 8'h00;
                mdl[2] = ex ? 8'h20 : 8'h00;
                rd(6);
                rd(2);
            end
        end
        $display("edge test done");
        // acceptance drops global enable and the pin flag only
        hall_pins <= 3'h0;
        comp_out <= 3'h0;
        ext_pin <= 1'b0;
        tick(8);
        wr(0, 8'h01);
        wr(1, 8'h01);
        wr(6, 8'h01);
        wr(2, 8'h07);
        ack_dly <= 4'($urandom_range(0, 6));
        ack_bit_sel <= 3'(EXTPIN_BIT);
        ack_go <= 1'b1;
        hall_pins <= 3'h1;
        ext_pin <= 1'b1;
        tick(30);
        ack_go <= 1'b0;
        mdl[6] = 8'h11;
        mdl[2] = 8'h16;
        rd_all();
        $display("acknowledge test done");
        results();
    end
endmodule : tb
